// ==== iglc_disp_if.sv ====
// Interface carrying the display request from sequencer to LED pattern engine
`timescale 1ns/1ps
interface iglc_disp_if;
  iglc_pkg::iglc_disp_e mode;
  logic [3:0]           count;
  logic                 tick;
  modport src (output mode, output count, output tick);
  modport dst (input mode, input count, input tick);
endinterface

// ==== iglc_led_pattern.sv ====
// LED pattern engine: off, fast blink, heartbeat, flame readout and fault code
`timescale 1ns/1ps
module iglc_led_pattern
  import iglc_pkg::*;
(
  // Clock and reset
  input  wire logic  i_sys_clk,
  input  wire logic  i_nrst,
  // Display request
  iglc_disp_if.dst   disp,
  // LED drive
  output logic       o_led
);
  typedef struct packed {
    iglc_disp_e mode;
    logic [3:0] count;
    logic [3:0] done;
    logic [1:0] phase;
    logic [11:0] ms;
    logic [3:0] pwm;
    logic       led;
  } iglc_pat_s;

  iglc_pat_s st_r;
  iglc_pat_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.pwm = st_r.pwm + 4'h1;
    if (disp.mode != st_r.mode || disp.count != st_r.count) begin
      // Clean restart on any change of shown pattern (see R13)
      st_nxt.mode  = disp.mode;
      st_nxt.count = disp.count;
      st_nxt.done  = 4'h0;
      st_nxt.phase = 2'd0;
      st_nxt.ms    = 12'h000;
    end else if (disp.tick) begin
      st_nxt.ms = st_r.ms + 12'h001;
      case (st_r.mode)
        IGLC_DISP_FAST, IGLC_DISP_BEAT: begin
          if (st_r.mode == IGLC_DISP_FAST ? st_r.ms == 12'(FAST_HALF_MS - 1)
                                          : st_r.ms == 12'(BEAT_HALF_MS - 1)) begin
            st_nxt.ms = 12'h000;
            st_nxt.phase = {1'b0, ~st_r.phase[0]};
          end
        end
        IGLC_DISP_FLAME: begin
          // 4 s on, then one 1 s flash per microampere (see R01)
          if (st_r.phase == 2'd0 && st_r.ms == 12'(SOLID_MS - 1)) begin
            st_nxt.ms = 12'h000;
            st_nxt.phase = (st_r.count == 4'h0) ? 2'd0 : 2'd1;
          end else if (st_r.phase != 2'd0 && st_r.ms == 12'(FLAME_FLASH_MS / 2 - 1)) begin
            st_nxt.ms = 12'h000;
            if (st_r.phase == 2'd1) begin
              st_nxt.phase = 2'd2;
            end else if (st_r.done + 4'h1 >= st_r.count) begin
              st_nxt.phase = 2'd0;
              st_nxt.done = 4'h0;
            end else begin
              st_nxt.phase = 2'd1;
              st_nxt.done = st_r.done + 4'h1;
            end
          end
        end
        IGLC_DISP_CODE: begin
          // N flashes at 2 Hz, then 2 s dark, repeat (see R02)
          if (st_r.phase == 2'd3) begin
            if (st_r.ms == 12'(CODE_GAP_MS - 1)) begin
              st_nxt.ms = 12'h000;
              st_nxt.phase = 2'd0;
              st_nxt.done = 4'h0;
            end
          end else if (st_r.ms == 12'(CODE_HALF_MS - 1)) begin
            st_nxt.ms = 12'h000;
            if (st_r.phase == 2'd0) begin
              st_nxt.phase = 2'd1;
            end else if (st_r.done + 4'h1 >= st_r.count) begin
              st_nxt.phase = 2'd3;
            end else begin
              st_nxt.phase = 2'd0;
              st_nxt.done = st_r.done + 4'h1;
            end
          end
        end
        default: begin
          st_nxt.ms = 12'h000;
        end
      endcase
    end
    case (st_nxt.mode)
      IGLC_DISP_FAST:  st_nxt.led = ~st_nxt.phase[0];
      // Bright half then dim half (see R03)
      IGLC_DISP_BEAT:  st_nxt.led = ~st_nxt.phase[0] | (st_nxt.pwm < DIM_DUTY);
      IGLC_DISP_FLAME: st_nxt.led = (st_nxt.phase != 2'd2);
      IGLC_DISP_CODE:  st_nxt.led = (st_nxt.phase == 2'd0) && (st_nxt.count != 4'h0);
      default:         st_nxt.led = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '{mode: IGLC_DISP_OFF, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_led = st_r.led;

  AST_SOLID_ON: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see R01
    (st_r.mode == IGLC_DISP_FLAME && st_r.phase == 2'd0) |-> o_led)
    else $error("Flame readout not solid during lead-in");
  AST_CODE_GAP_DARK: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see R02
    (st_r.mode == IGLC_DISP_CODE && st_r.phase == 2'd3) |-> !o_led)
    else $error("LED lit during code gap");
  AST_RESTART: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see R13
    (disp.mode != st_r.mode || disp.count != st_r.count)
    |=> (st_r.ms == 12'h000 && st_r.done == 4'h0 && st_r.phase == 2'd0))
    else $error("Pattern not restarted on code change");
endmodule

// ==== iglc_pkg.sv ====
// Package of timing constants, codes and types for the ignition status LED coder
package iglc_pkg;
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned TICK_MS        = 1;
  localparam int unsigned TICK_CYC       = CLK_HZ / 1000 * TICK_MS;
  // Pattern times in milliseconds
  localparam int unsigned SOLID_MS       = 4000;
  localparam int unsigned FLAME_FLASH_MS = 1000;
  localparam int unsigned CODE_HALF_MS   = 250;
  localparam int unsigned CODE_GAP_MS    = 2000;
  localparam int unsigned BEAT_HALF_MS   = 500;
  localparam int unsigned FAST_HALF_MS   = 100;
  // Fault reaction times in seconds
  localparam int unsigned RETRY_S        = 300;
  localparam int unsigned OOS_LIMIT_S    = 10;
  localparam int unsigned HOLDOFF_S      = 3600;
  localparam int unsigned DAMPER_S       = 60;
  localparam int unsigned MS_PER_S       = 1000;
  // Dim level as PWM duty out of 16
  localparam logic [3:0]  DIM_DUTY       = 4'h4;
  // Fault codes
  localparam logic [3:0]  CODE_NONE      = 4'h0;
  localparam logic [3:0]  CODE_RETRY     = 4'h2;
  localparam logic [3:0]  CODE_RECYCLE   = 4'h3;
  localparam logic [3:0]  CODE_OOS       = 4'h4;
  localparam logic [3:0]  CODE_DAMPER    = 4'h5;
  localparam logic [3:0]  CODE_INTERNAL  = 4'h6;
  localparam logic [3:0]  CODE_ROD_SHORT = 4'h7;
  localparam logic [3:0]  CODE_LOW_SUPPLY = 4'h8;
  // Display modes
  typedef enum logic [4:0] {
    IGLC_DISP_OFF   = 5'b00001,
    IGLC_DISP_FAST  = 5'b00010,
    IGLC_DISP_BEAT  = 5'b00100,
    IGLC_DISP_FLAME = 5'b01000,
    IGLC_DISP_CODE  = 5'b10000
  } iglc_disp_e;
endpackage

// ==== iglc_status_top.sv ====
// Ignition fault-reaction sequencer and status LED coder top level
//
// Operation
// R01: In run mode, 4 s on, then one 1 s flash per microampere.
// R02: Fault code N: N flashes at 2 Hz, 2 s dark, repeat.
// R03: Heartbeat: half second bright, half second dim, continuously.
// R04: No pilot flame in trial: code 2, 5 minute delay, new trial.
// R05: Flame lost in run: code 3, new trial, code until proven.
// R06: Out-of-sequence flame: code 4; clears within 10 s returns normal.
// R07: Longer than 10 s: resume one hour after condition clears.
// R08: Code 5 for damper absent, fails open or close in 60 s.
// R09: Damper fault cleared: resume ignition automatically.
// R10: Code 6 internal, 7 rod shorted, 8 low secondary supply.
// R11: Codes 6 to 8 wait while present, resume when cleared.
// R12: Dark without demand, fast blink at power-up check, heartbeat in sequence.
// R13: One code by fixed priority; pattern restarts when code changes.
`timescale 1ns/1ps
module iglc_status_top
  import iglc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int unsigned RETRY_MS    = RETRY_S * MS_PER_S,
  parameter int unsigned OOS_MS      = OOS_LIMIT_S * MS_PER_S,
  parameter int unsigned HOLDOFF_MS  = HOLDOFF_S * MS_PER_S,
  parameter int unsigned DAMPER_MS   = DAMPER_S * MS_PER_S
) (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  // Appliance state
  input  wire logic       i_heat_call,
  input  wire logic       i_selftest,
  input  wire logic       i_in_trial,
  input  wire logic       i_run,
  input  wire logic       i_flame,
  input  wire logic       i_trial_fail,
  input  wire logic [3:0] i_flame_ua,
  // Damper
  input  wire logic       i_damper_req,
  input  wire logic       i_damper_present,
  input  wire logic       i_damper_cmd_open,
  input  wire logic       i_damper_open,
  input  wire logic       i_damper_closed,
  // Faults
  input  wire logic       i_internal_err,
  input  wire logic       i_rod_short,
  input  wire logic       i_low_supply,
  // Sequence control
  output logic            o_start_trial,
  output logic            o_wait,
  output logic [3:0]      o_code,
  // LED
  output logic            o_led
);
  typedef struct packed {
    logic [15:0] div;
    logic [21:0] retry_ms;
    logic        retry;
    logic        recycle;
    logic [13:0] oos_ms;
    logic        oos_long;
    logic        holdoff;
    logic [21:0] hold_ms;
    logic [15:0] dmp_ms;
    logic        dmp_fail;
    logic        start;
  } iglc_seq_s;

  iglc_seq_s st_r;
  iglc_seq_s st_nxt;
  logic      tick;
  logic      oos_flame;
  logic      dmp_moving;
  logic      dmp_absent;
  logic      dmp_err;
  logic [3:0] code;

  iglc_disp_if disp ();

  assign tick       = (st_r.div == 16'(TICK_CYCLES - 1));
  assign oos_flame  = i_flame && !i_in_trial && !i_run;
  assign dmp_absent = i_damper_req && !i_damper_present;
  assign dmp_moving = i_damper_present &&
                      (i_damper_cmd_open ? !i_damper_open : !i_damper_closed);
  assign dmp_err    = dmp_absent || st_r.dmp_fail; // see R08

  always_comb begin
    st_nxt = st_r;
    st_nxt.start = 1'b0;
    st_nxt.div = tick ? 16'h0000 : st_r.div + 16'h0001;
    // Retry delay after failed trial (see R04)
    if (i_trial_fail && !st_r.retry) begin
      st_nxt.retry = 1'b1;
      st_nxt.retry_ms = 22'h0;
    end else if (st_r.retry && tick) begin
      if (st_r.retry_ms == 22'(RETRY_MS - 1)) begin
        st_nxt.retry = 1'b0;
        st_nxt.start = 1'b1;
      end else begin
        st_nxt.retry_ms = st_r.retry_ms + 22'h1;
      end
    end
    // Recycle: new trial, code held until flame proven (see R05)
    if (i_run && !i_flame && !st_r.recycle) begin
      st_nxt.recycle = 1'b1;
      st_nxt.start = 1'b1;
    end else if (st_r.recycle && i_flame && i_in_trial) begin
      st_nxt.recycle = 1'b0;
    end
    // Out-of-sequence flame timing (see R06)
    if (!oos_flame) begin
      st_nxt.oos_ms = 14'h0;
      st_nxt.oos_long = 1'b0;
      if (st_r.oos_long) begin
        st_nxt.holdoff = 1'b1; // see R07
        st_nxt.hold_ms = 22'h0;
      end
    end else if (tick && !st_r.oos_long) begin
      if (st_r.oos_ms == 14'(OOS_MS - 1)) begin
        st_nxt.oos_long = 1'b1;
      end else begin
        st_nxt.oos_ms = st_r.oos_ms + 14'h1;
      end
    end
    // Re-arm from a fresh long condition wins over the countdown end (see R07)
    if (st_r.holdoff && !oos_flame && !st_r.oos_long && tick) begin
      if (st_r.hold_ms == 22'(HOLDOFF_MS - 1)) begin
        st_nxt.holdoff = 1'b0;
      end else begin
        st_nxt.hold_ms = st_r.hold_ms + 22'h1;
      end
    end
    // Damper travel watchdog, self clears when damper settles (see R09)
    if (!dmp_moving) begin
      st_nxt.dmp_ms = 16'h0;
      st_nxt.dmp_fail = 1'b0;
    end else if (tick && !st_r.dmp_fail) begin
      if (st_r.dmp_ms == 16'(DAMPER_MS - 1)) begin
        st_nxt.dmp_fail = 1'b1;
      end else begin
        st_nxt.dmp_ms = st_r.dmp_ms + 16'h1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Fixed priority, highest first (see R13)
  always_comb begin
    if (i_internal_err) begin
      code = CODE_INTERNAL; // see R10
    end else if (i_rod_short) begin
      code = CODE_ROD_SHORT;
    end else if (i_low_supply) begin
      code = CODE_LOW_SUPPLY;
    end else if (oos_flame || st_r.holdoff) begin
      code = CODE_OOS;
    end else if (dmp_err) begin
      code = CODE_DAMPER;
    end else if (st_r.retry) begin
      code = CODE_RETRY;
    end else if (st_r.recycle) begin
      code = CODE_RECYCLE;
    end else begin
      code = CODE_NONE;
    end
  end

  // Wait while any blocking fault or hold-off stands (see R11)
  assign o_wait        = (code != CODE_NONE) && (code != CODE_RECYCLE);
  assign o_start_trial = st_r.start && !o_wait;
  assign o_code        = code;

  assign disp.tick  = tick;
  assign disp.count = (code != CODE_NONE) ? code :
                      (i_run && i_flame) ? i_flame_ua : 4'h0;
  // Display selection (see R12)
  always_comb begin
    if (code != CODE_NONE) begin
      disp.mode = IGLC_DISP_CODE;
    end else if (i_selftest) begin
      disp.mode = IGLC_DISP_FAST;
    end else if (!i_heat_call) begin
      disp.mode = IGLC_DISP_OFF;
    end else if (i_run && i_flame) begin
      disp.mode = IGLC_DISP_FLAME;
    end else begin
      disp.mode = IGLC_DISP_BEAT;
    end
  end

  iglc_led_pattern u_pattern (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .disp      (disp),
    .o_led     (o_led)
  );

  sequence s_trial_fail;
    i_trial_fail && !st_r.retry;
  endsequence
  AST_RETRY_CODE: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see R04
    s_trial_fail |=> st_r.retry)
    else $error("Retry delay not started");
  AST_RECYCLE_START: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see R05
    (i_run && !i_flame && !st_r.recycle) |=> st_r.start && st_r.recycle)
    else $error("Recycle did not start trial");
  AST_HOLDOFF: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see R07
    (st_r.oos_long && !oos_flame) |=> st_r.holdoff)
    else $error("Hold-off not armed");
  AST_DAMPER_CODE: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see R08
    (dmp_absent && !i_internal_err && !i_rod_short && !i_low_supply && !oos_flame
     && !st_r.holdoff) |-> code == CODE_DAMPER)
    else $error("Damper code missing");
  AST_FAULT_WAIT: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see R11
    (i_internal_err || i_rod_short || i_low_supply) |-> o_wait && !o_start_trial)
    else $error("Not waiting under fault");
  AST_DARK_IDLE: assert property (@(posedge i_sys_clk) disable iff (!i_nrst) // see R12
    (!i_heat_call && !i_selftest && code == CODE_NONE) |-> disp.mode == IGLC_DISP_OFF)
    else $error("Display not off without demand");
endmodule

// ==== tb_ignition_status_led_coder.sv ====
// Self-checking testbench for the ignition status LED coder
`timescale 1ns/1ps
module tb_ignition_status_led_coder;
  import iglc_pkg::*;
  logic       i_sys_clk, i_nrst, i_heat_call, i_selftest, i_in_trial, i_run, i_flame;
  logic       i_trial_fail, i_damper_req, i_damper_present, i_damper_cmd_open;
  logic       i_damper_open, i_damper_closed, i_internal_err, i_rod_short, i_low_supply;
  logic [3:0] i_flame_ua;
  logic       o_start_trial, o_wait, o_led;
  logic [3:0] o_code;
  int         error_cnt, checks_done;
  int         cyc = 0;

  iglc_status_top #(
    .TICK_CYCLES(2), .RETRY_MS(5), .OOS_MS(5), .HOLDOFF_MS(8), .DAMPER_MS(5)
  ) dut (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_heat_call(i_heat_call),
    .i_selftest(i_selftest), .i_in_trial(i_in_trial), .i_run(i_run), .i_flame(i_flame),
    .i_trial_fail(i_trial_fail), .i_flame_ua(i_flame_ua), .i_damper_req(i_damper_req),
    .i_damper_present(i_damper_present), .i_damper_cmd_open(i_damper_cmd_open),
    .i_damper_open(i_damper_open), .i_damper_closed(i_damper_closed),
    .i_internal_err(i_internal_err), .i_rod_short(i_rod_short),
    .i_low_supply(i_low_supply), .o_start_trial(o_start_trial), .o_wait(o_wait),
    .o_code(o_code), .o_led(o_led)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  // Ends the run
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Step n edges, inputs change 1 ns after
  task automatic step(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  // Lit cycles, LED falls and start pulses over n cycles
  task automatic watch(input int n, output int ons, output int falls, output int starts);
    logic prev;
    ons = 0;
    falls = 0;
    starts = 0;
    repeat (n) begin
      prev = o_led;
      step(1);
      ons += (o_led === 1'b1);
      falls += (prev === 1'b1 && o_led === 1'b0);
      starts += (o_start_trial === 1'b1);
    end
  endtask

  task automatic code_is(input logic [3:0] c, input logic w);
    chk({12'h000, o_code}, {12'h000, c});
    chk({15'h0000, o_wait}, {15'h0000, w});
  endtask

  task automatic t_idle_beat();
    int on, fa, st;
    watch(500, on, fa, st);
    chk(on[15:0], 16'h0000);
    i_selftest = 1'b1;
    watch(2000, on, fa, st);
    chk(fa[15:0], 16'h0005);
    i_selftest = 1'b0;
    i_heat_call = 1'b1;
    i_in_trial = 1'b1;
    step(10);
    watch(980, on, fa, st);
    chk(on[15:0], 16'd980);
    step(30);
    watch(980, on, fa, st);
    chk({15'h0000, on > 150 && on < 350}, 16'h0001);
  endtask

  task automatic t_flame_run();
    int on, fa, st;
    i_in_trial = 1'b0;
    i_run = 1'b1;
    i_flame = 1'b1;
    i_flame_ua = 4'h3;
    watch(14400, on, fa, st);
    chk(fa[15:0], 16'h0003);
    code_is(CODE_NONE, 1'b0);
  endtask

  task automatic t_recycle();
    int on, fa, st;
    i_flame = 1'b0;
    watch(4, on, fa, st);
    chk(st[15:0], 16'h0001);
    i_run = 1'b0;
    i_in_trial = 1'b1;
    step(20);
    code_is(CODE_RECYCLE, 1'b0);
    i_flame = 1'b1;
    step(2);
    code_is(CODE_NONE, 1'b0);
  endtask

  task automatic t_retry();
    int on, fa, st;
    i_flame = 1'b0;
    i_trial_fail = 1'b1;
    step(1);
    i_trial_fail = 1'b0;
    step(1);
    code_is(CODE_RETRY, 1'b1);
    watch(40, on, fa, st);
    chk(st[15:0], 16'h0001);
    code_is(CODE_NONE, 1'b0);
  endtask

  task automatic t_faults();
    int on, fa, st;
    logic [2:0] v;
    i_in_trial = 1'b0;
    for (int k = 0; k < 3; k++) begin
      v = 3'b111 >> k;
      {i_internal_err, i_rod_short, i_low_supply} = v;
      step(1);
      code_is(CODE_INTERNAL + 4'(k), 1'b1);
      watch((6 + k) * 1000 + 3600, on, fa, st);
      chk(fa[15:0], 16'(6 + k));
    end
    i_low_supply = 1'b0;
    step(1);
    code_is(CODE_NONE, 1'b0);
  endtask

  task automatic t_oos();
    i_flame = 1'b1;
    step(2);
    code_is(CODE_OOS, 1'b1);
    step(4);
    i_flame = 1'b0;
    step(2);
    code_is(CODE_NONE, 1'b0);
    i_flame = 1'b1;
    step(30);
    i_flame = 1'b0;
    step(6);
    code_is(CODE_OOS, 1'b1);
    step(30);
    code_is(CODE_NONE, 1'b0);
  endtask

  task automatic t_damper();
    i_damper_req = 1'b1;
    i_damper_present = 1'b0;
    step(2);
    code_is(CODE_DAMPER, 1'b1);
    i_damper_present = 1'b1;
    step(2);
    code_is(CODE_NONE, 1'b0);
    i_damper_cmd_open = 1'b1;
    i_damper_closed = 1'b0;
    step(4);
    code_is(CODE_NONE, 1'b0);
    step(20);
    code_is(CODE_DAMPER, 1'b1);
    i_damper_open = 1'b1;
    step(2);
    code_is(CODE_NONE, 1'b0);
  endtask

  initial begin
    {i_nrst, i_heat_call, i_selftest, i_in_trial, i_run, i_flame, i_trial_fail} = '0;
    {i_damper_req, i_damper_present, i_damper_cmd_open, i_damper_open} = '0;
    {i_internal_err, i_rod_short, i_low_supply} = '0;
    i_damper_closed = 1'b1;
    i_flame_ua = 4'h0;
    error_cnt = 0;
    checks_done = 0;
    step(20);
    i_nrst = 1'b1;
    step(2);
    t_idle_beat();
    t_flame_run();
    t_recycle();
    t_retry();
    t_faults();
    t_oos();
    t_damper();
    print_verdict();
  end
endmodule
